/* core/ramp_pkg.sv */
// Shared constants and types for the vector ramp generator
package ramp_pkg;
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Setting ranges and reset values, microseconds or LSBs
  localparam logic [15:0] STEP_MIN_3AX  = 16'h010e;
  localparam logic [15:0] STEP_MIN_2AX  = 16'h00a2;
  localparam logic [15:0] STEP_MAX      = 16'hfffe;
  localparam logic [15:0] STEP_RST_3AX  = 16'h010e;
  localparam logic [15:0] STEP_RST_2AX  = 16'h00d2;
  localparam logic [15:0] INC_MIN       = 16'h0001;
  localparam logic [15:0] INC_MAX       = 16'h7fff;
  localparam logic [15:0] DRAW_INC_RST  = 16'h0020;
  localparam logic [15:0] JUMP_INC_RST  = 16'h0200;
  localparam logic [15:0] SETTLE_MIN    = 16'h0002;
  localparam logic [15:0] SETTLE_MAX    = 16'hfffe;
  localparam logic [15:0] PRE_RST       = 16'h0002;
  localparam logic [15:0] POST_RST      = 16'h0bb8;
  localparam logic [15:0] COORD_RST     = 16'h8000;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_STEP       = 8'h08;
  localparam logic [7:0] OFS_DRAW_INC   = 8'h0c;
  localparam logic [7:0] OFS_JUMP_INC   = 8'h10;
  localparam logic [7:0] OFS_PRE        = 8'h14;
  localparam logic [7:0] OFS_POST       = 8'h18;
  localparam logic [7:0] OFS_VEC_X      = 8'h1c;
  localparam logic [7:0] OFS_VEC_Y      = 8'h20;
  localparam logic [7:0] OFS_POS        = 8'h24;
  // Field positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 1;
  localparam int unsigned VEC_JUMP_BIT   = 16;
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_REJECT_BIT  = 1;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef enum logic [3:0] {
    EX_IDLE, EX_FETCH, EX_LOAD, EX_DIV_N, EX_DIV_X, EX_DIV_Y, EX_PRE, EX_RAMP, EX_POST, EX_NEXT
  } exec_state_t;
endpackage : ramp_pkg

/* core/udiv16.sv */
// Sequential 16-bit unsigned divider, one quotient bit per cycle
`timescale 1ns/1ps
`default_nettype none
module udiv16
  import ramp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [15:0] dividend,
  input  wire logic [15:0] divisor,
  output logic             done,
  output logic [15:0]      quotient,
  output logic [15:0]      remainder
);
  logic [16:0] rem_q, rem_d;
  logic [15:0] quo_q, quo_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        done_q, done_d;
  logic [16:0] shifted;

  always_comb
  begin
    rem_d   = rem_q;
    quo_d   = quo_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    shifted = {rem_q[15:0], quo_q[15]};
    if (start)
    begin
      rem_d = 17'h00000;
      quo_d = dividend;
      cnt_d = 5'h10;
    end
    else if (cnt_q != 5'h00)
    begin
      // Divisor zero gives all-ones quotient; EX_DIV_X starts it when n is zero but ignores the result
      if (shifted >= {1'b0, divisor})
      begin
        rem_d = shifted - {1'b0, divisor};
        quo_d = {quo_q[14:0], 1'b1};
      end
      else
      begin
        rem_d = shifted;
        quo_d = {quo_q[14:0], 1'b0};
      end
      cnt_d  = cnt_q - 5'h01;
      done_d = (cnt_q == 5'h01);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rem_q  <= 17'h00000;
      quo_q  <= 16'h0000;
      cnt_q  <= 5'h00;
      done_q <= 1'b0;
    end
    else
    begin
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done      = done_q;
  assign quotient  = quo_q;
  assign remainder = rem_q[15:0];
endmodule : udiv16
`default_nettype wire

/* core/vector_mem.sv */
// Vector table storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module vector_mem #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             ref_clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic [WIDTH-1:0]      rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end
endmodule : vector_mem
`default_nettype wire

/* core/vector_ramp.sv */
// Two-axis vector ramp generator with step timing, increments and settling
// Functional notes
// - Step interval accepted only within 270..65534 us when TWO_AXIS is clear.
// - Step interval is microseconds between successive DAC increments.
// - Step interval change applies at once, also to stored vectors.
// - Two-axis variant accepts step intervals down to 162 us.
// - Draw and jump increments accepted within 1..32767 LSB.
// - Position unit is 1/65536 of field; coordinates are 16 bits.
// - Drawn vectors advance by at most the draw increment per step.
// - Jump vectors advance by at most the jump increment per step.
// - Vector takes length over increment steps, one step interval each.
// - Settle delays accepted within 2..65534 us; only even values realised.
// - Pre-draw settle precedes each drawn vector, never a jump.
// - Post-jump settle follows each jump, never a drawn vector.
// - Settle settings apply at once to every stored vector.
// - Settle delays reset to 2 us pre-draw and 3000 us post-jump.
// - Each entered pair stores its endpoint and per-step increment.
// - Increment changes affect only pairs entered afterwards.
// - Laser stays off during jumps.
`timescale 1ns/1ps
`default_nettype none
module vector_ramp
  import ramp_pkg::*;
#(
  parameter bit          TWO_AXIS = 1'b0,
  parameter int unsigned DEPTH    = 256
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [15:0]      dac_x,
  output logic [15:0]      dac_y,
  output logic             laser_on
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [15:0] STEP_MIN = TWO_AXIS ? STEP_MIN_2AX : STEP_MIN_3AX;
  localparam logic [15:0] STEP_RST = TWO_AXIS ? STEP_RST_2AX : STEP_RST_3AX;
  localparam logic [3:0]  US_LAST  = 4'(CYC_PER_US - 1);

  // Bus and settings state
  logic [15:0] step_q, step_d, draw_inc_q, draw_inc_d, jump_inc_q, jump_inc_d;
  logic [15:0] pre_q, pre_d, post_q, post_d, vx_q, vx_d;
  logic        vjump_q, vjump_d, reject_q, reject_d, start_q, start_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, wd;
  logic [AW:0] count_q, count_d;
  logic        wr_go, wr_ok, rd_go, push;
  logic [47:0] push_data;
  logic [15:0] push_y;

  // Execution state
  exec_state_t st_q, st_d;
  logic [AW-1:0] idx_q, idx_d;
  logic [15:0] x_q, x_d, y_q, y_d, ex_q, ex_d, ey_q, ey_d, inc_q, inc_d;
  logic [15:0] n_q, n_d, k_q, k_d, qx_q, qx_d, qy_q, qy_d, ucnt_q, ucnt_d;
  logic [16:0] rx_q, rx_d, ry_q, ry_d, rx_sum, ry_sum;
  logic [15:0] rxr_q, rxr_d, ryr_q, ryr_d, adx, ady, len;
  logic        jmp_q, jmp_d, sx_q, sx_d, sy_q, sy_d, laser_q, laser_d;
  logic [3:0]  tick_q, tick_d;
  logic        us_tick, busy;
  logic [47:0] rd_entry;
  logic        div_start, div_done;
  logic [15:0] div_a, div_b, div_quo, div_rem, nx_step, ny_step;

  assign busy  = (st_q != EX_IDLE);
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign wr_ok = wr_go && (s_axi_wstrb == 4'hf);
  assign rd_go = s_axi_arvalid && !rvalid_q;
  assign wd    = s_axi_wdata;
  assign push_y = wd[15:0];
  // Table writes are refused while running so execution sees a fixed list
  assign push  = wr_ok && (s_axi_awaddr == OFS_VEC_Y) && !busy && (count_q < (AW+1)'(DEPTH));
  // Increment is frozen into the entry at entry time
  assign push_data = {vjump_q, vjump_q ? jump_inc_q[14:0] : draw_inc_q[14:0], vx_q, push_y};

  always_comb
  begin
    step_d = step_q; draw_inc_d = draw_inc_q; jump_inc_d = jump_inc_q;
    pre_d = pre_q; post_d = post_q; vx_d = vx_q; vjump_d = vjump_q;
    reject_d = reject_q; start_d = 1'b0; count_d = count_q;
    bvalid_d = bvalid_q && !s_axi_bready; bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready; rresp_d = rresp_q; rdata_d = rdata_q;
    if (wr_go)
    begin
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      if (wr_ok)
      begin
        unique case (s_axi_awaddr)
          OFS_CTRL:
          begin
            start_d = wd[CTRL_START_BIT] && !busy;
            if (wd[CTRL_CLEAR_BIT] && !busy)
              count_d = '0;
          end
          OFS_STATUS:
            if (wd[ST_REJECT_BIT])
              reject_d = 1'b0;
          OFS_STEP:
            if (wd[31:16] == 16'h0000 && wd[15:0] >= STEP_MIN && wd[15:0] <= STEP_MAX)
              step_d = wd[15:0];
            else
              reject_d = 1'b1;
          OFS_DRAW_INC:
            if (wd[31:16] == 16'h0000 && wd[15:0] >= INC_MIN && wd[15:0] <= INC_MAX)
              draw_inc_d = wd[15:0];
            else
              reject_d = 1'b1;
          OFS_JUMP_INC:
            if (wd[31:16] == 16'h0000 && wd[15:0] >= INC_MIN && wd[15:0] <= INC_MAX)
              jump_inc_d = wd[15:0];
            else
              reject_d = 1'b1;
          OFS_PRE:
            if (wd[31:16] == 16'h0000 && wd[15:0] >= SETTLE_MIN && wd[15:0] <= SETTLE_MAX)
              pre_d = wd[15:0];
            else
              reject_d = 1'b1;
          OFS_POST:
            if (wd[31:16] == 16'h0000 && wd[15:0] >= SETTLE_MIN && wd[15:0] <= SETTLE_MAX)
              post_d = wd[15:0];
            else
              reject_d = 1'b1;
          OFS_VEC_X:
          begin
            vx_d    = wd[15:0];
            vjump_d = wd[VEC_JUMP_BIT];
          end
          OFS_VEC_Y:
            if (push)
              count_d = count_q + (AW+1)'(1);
            else
              reject_d = 1'b1;
          OFS_POS: ;
          default: bresp_d = RESP_SLVERR;
        endcase
      end
    end
    if (rd_go)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL:     rdata_d = 32'h00000000;
        OFS_STATUS:   rdata_d = {16'(count_q), 14'h0000, reject_q, busy};
        OFS_STEP:     rdata_d = {16'h0000, step_q};
        OFS_DRAW_INC: rdata_d = {16'h0000, draw_inc_q};
        OFS_JUMP_INC: rdata_d = {16'h0000, jump_inc_q};
        OFS_PRE:      rdata_d = {16'h0000, pre_q};
        OFS_POST:     rdata_d = {16'h0000, post_q};
        OFS_VEC_X:    rdata_d = {15'h0000, vjump_q, vx_q};
        OFS_VEC_Y:    rdata_d = 32'h00000000;
        OFS_POS:      rdata_d = {y_q, x_q};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      step_q <= STEP_RST; draw_inc_q <= DRAW_INC_RST; jump_inc_q <= JUMP_INC_RST;
      pre_q <= PRE_RST; post_q <= POST_RST;
      vx_q <= COORD_RST; vjump_q <= 1'b0; reject_q <= 1'b0; start_q <= 1'b0;
      count_q <= '0; bvalid_q <= 1'b0; bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0; rresp_q <= RESP_OKAY; rdata_q <= 32'h00000000;
    end
    else
    begin
      step_q <= step_d; draw_inc_q <= draw_inc_d; jump_inc_q <= jump_inc_d;
      pre_q <= pre_d; post_q <= post_d; vx_q <= vx_d; vjump_q <= vjump_d;
      reject_q <= reject_d; start_q <= start_d; count_q <= count_d;
      bvalid_q <= bvalid_d; bresp_q <= bresp_d;
      rvalid_q <= rvalid_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
    end
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  vector_mem #(.WIDTH(48), .DEPTH(DEPTH)) u_mem (
    .ref_clk (ref_clk),
    .wr_en   (push),
    .wr_addr (count_q[AW-1:0]),
    .wr_data (push_data),
    .rd_addr (idx_q),
    .rd_data (rd_entry)
  );

  udiv16 u_div (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .start     (div_start),
    .dividend  (div_a),
    .divisor   (div_b),
    .done      (div_done),
    .quotient  (div_quo),
    .remainder (div_rem)
  );

  // Vector length taken as the larger axis move
  assign adx = sx_q ? ex_q - x_q : x_q - ex_q;
  assign ady = sy_q ? ey_q - y_q : y_q - ey_q;
  assign len = (adx > ady) ? adx : ady;
  assign us_tick = (tick_q == US_LAST);
  assign rx_sum = rx_q + {1'b0, rxr_q};
  assign ry_sum = ry_q + {1'b0, ryr_q};
  assign nx_step = qx_q + ((rx_sum >= {1'b0, n_q}) ? 16'h0001 : 16'h0000);
  assign ny_step = qy_q + ((ry_sum >= {1'b0, n_q}) ? 16'h0001 : 16'h0000);

  always_comb
  begin
    st_d = st_q; idx_d = idx_q; x_d = x_q; y_d = y_q; ex_d = ex_q; ey_d = ey_q;
    inc_d = inc_q; n_d = n_q; k_d = k_q; qx_d = qx_q; qy_d = qy_q; ucnt_d = ucnt_q;
    rx_d = rx_q; ry_d = ry_q; rxr_d = rxr_q; ryr_d = ryr_q; jmp_d = jmp_q;
    sx_d = sx_q; sy_d = sy_q; laser_d = 1'b0;
    tick_d = us_tick ? 4'h0 : tick_q + 4'h1;
    div_start = 1'b0; div_a = len; div_b = inc_q;
    unique case (st_q)
      EX_IDLE:
        if (start_q && count_q != '0)
        begin
          idx_d = '0;
          st_d  = EX_FETCH;
        end
      EX_FETCH: st_d = EX_LOAD;
      EX_LOAD:
      begin
        jmp_d = rd_entry[47];
        inc_d = {1'b0, rd_entry[46:32]};
        ex_d  = rd_entry[31:16];
        ey_d  = rd_entry[15:0];
        sx_d  = rd_entry[31:16] >= x_q;
        sy_d  = rd_entry[15:0] >= y_q;
        div_start = 1'b0;
        st_d  = EX_DIV_N;
      end
      EX_DIV_N:
      begin
        div_start = (k_q == 16'h0000);
        k_d = 16'h0001;
        if (div_done)
        begin
          n_d  = div_quo + ((div_rem != 16'h0000) ? 16'h0001 : 16'h0000);
          k_d  = 16'h0000;
          st_d = EX_DIV_X;
        end
      end
      EX_DIV_X:
      begin
        div_a = adx; div_b = n_q;
        div_start = (k_q == 16'h0000);
        k_d = 16'h0001;
        if (n_q == 16'h0000)
        begin
          k_d = 16'h0000; ucnt_d = 16'h0000;
          st_d = jmp_q ? EX_POST : EX_PRE;
        end
        else if (div_done)
        begin
          qx_d = div_quo; rxr_d = div_rem; k_d = 16'h0000;
          st_d = EX_DIV_Y;
        end
      end
      EX_DIV_Y:
      begin
        div_a = ady; div_b = n_q;
        div_start = (k_q == 16'h0000);
        k_d = 16'h0001;
        if (div_done)
        begin
          qy_d = div_quo; ryr_d = div_rem; k_d = 16'h0000;
          rx_d = 17'h00000; ry_d = 17'h00000; ucnt_d = 16'h0000;
          st_d = jmp_q ? EX_RAMP : EX_PRE;
        end
      end
      EX_PRE:
        if (ucnt_q >= {pre_q[15:1], 1'b0})
        begin
          ucnt_d = 16'h0000;
          st_d   = (n_q == 16'h0000) ? EX_NEXT : EX_RAMP;
        end
        else if (us_tick)
          ucnt_d = ucnt_q + 16'h0001;
      EX_RAMP:
      begin
        laser_d = !jmp_q;
        if (us_tick)
        begin
          // Step interval read live so a change lands mid-vector
          if (ucnt_q + 16'h0001 >= step_q)
          begin
            ucnt_d = 16'h0000;
            k_d    = k_q + 16'h0001;
            rx_d   = (rx_sum >= {1'b0, n_q}) ? rx_sum - {1'b0, n_q} : rx_sum;
            ry_d   = (ry_sum >= {1'b0, n_q}) ? ry_sum - {1'b0, n_q} : ry_sum;
            x_d    = sx_q ? x_q + nx_step : x_q - nx_step;
            y_d    = sy_q ? y_q + ny_step : y_q - ny_step;
            if (k_q + 16'h0001 == n_q)
            begin
              x_d = ex_q; y_d = ey_q; k_d = 16'h0000;
              st_d = jmp_q ? EX_POST : EX_NEXT;
            end
          end
          else
            ucnt_d = ucnt_q + 16'h0001;
        end
      end
      EX_POST:
        if (ucnt_q >= {post_q[15:1], 1'b0})
        begin
          ucnt_d = 16'h0000;
          st_d   = EX_NEXT;
        end
        else if (us_tick)
          ucnt_d = ucnt_q + 16'h0001;
      EX_NEXT:
        if ((AW+1)'(idx_q) + (AW+1)'(1) >= count_q)
          st_d = EX_IDLE;
        else
        begin
          idx_d = idx_q + AW'(1);
          st_d  = EX_FETCH;
        end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= EX_IDLE; idx_q <= '0; x_q <= COORD_RST; y_q <= COORD_RST;
      ex_q <= COORD_RST; ey_q <= COORD_RST; inc_q <= 16'h0001; n_q <= 16'h0000;
      k_q <= 16'h0000; qx_q <= 16'h0000; qy_q <= 16'h0000; ucnt_q <= 16'h0000;
      rx_q <= 17'h00000; ry_q <= 17'h00000; rxr_q <= 16'h0000; ryr_q <= 16'h0000;
      jmp_q <= 1'b0; sx_q <= 1'b0; sy_q <= 1'b0; laser_q <= 1'b0; tick_q <= 4'h0;
    end
    else
    begin
      st_q <= st_d; idx_q <= idx_d; x_q <= x_d; y_q <= y_d; ex_q <= ex_d; ey_q <= ey_d;
      inc_q <= inc_d; n_q <= n_d; k_q <= k_d; qx_q <= qx_d; qy_q <= qy_d; ucnt_q <= ucnt_d;
      rx_q <= rx_d; ry_q <= ry_d; rxr_q <= rxr_d; ryr_q <= ryr_d;
      jmp_q <= jmp_d; sx_q <= sx_d; sy_q <= sy_d; laser_q <= laser_d; tick_q <= tick_d;
    end
  end

  assign dac_x    = x_q;
  assign dac_y    = y_q;
  assign laser_on = laser_q;
endmodule : vector_ramp
`default_nettype wire

/* dv/host_link.sv */
// Host model: AXI4-Lite master that sends settings and vector pairs
`timescale 1ns/1ps
`default_nettype none
module host_link
  import ramp_pkg::*;
(
  input  wire logic        ref_clk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ap;
    logic wp;
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    while (ap || wp)
    begin
      @(posedge ref_clk);
      ap = ap && !s_axi_awready;
      wp = wp && !s_axi_wready;
      s_axi_awvalid <= ap;
      s_axi_wvalid  <= wp;
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // X then Y back to back, so no setting ever splits a pair
  task automatic pair(input logic jmp, input logic [15:0] x, input logic [15:0] y);
    logic [1:0] r;
    wr(OFS_VEC_X, {15'h0000, jmp, x}, r);
    wr(OFS_VEC_Y, {16'h0000, y}, r);
  endtask : pair
endmodule : host_link
`default_nettype wire

/* dv/ramp_monitor.sv */
// Bus and step timing checks for the vector ramp generator
`timescale 1ns/1ps
`default_nettype none
module ramp_monitor
  import ramp_pkg::*;
#(
  parameter bit TWO_AXIS = 1'b0
) (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [15:0] dac_x,
  input wire logic [15:0] dac_y,
  input wire logic        laser_on
);
  // Shortest legal step; a slower programmed step only widens the gap
  localparam int MIN_GAP = (TWO_AXIS ? 162 : 270) * 10;
  logic [15:0] gap_q, gap_d, last_x_q, last_y_q;
  logic        lit_q, moved;

  always_comb
  begin
    moved = (dac_x != last_x_q) || (dac_y != last_y_q);
    gap_d = moved ? 16'h0001 : gap_q + {15'h0000, gap_q != 16'hffff};
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      {gap_q, last_x_q, last_y_q, lit_q} <= {16'hffff, COORD_RST, COORD_RST, 1'b0};
    else
      {gap_q, last_x_q, last_y_q, lit_q} <= {gap_d, dac_x, dac_y, laser_on};
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  AST_AW_W_TOGETHER: assert property (s_axi_awready == s_axi_wready
    && s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)) else $error("aw/w ready wrong");
  AST_B_AFTER_W: assert property (s_axi_awready |=> s_axi_bvalid) else $error("no write response");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_AFTER_AR: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read data");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read data dropped");
  AST_UNMAPPED_W: assert property (s_axi_awready && s_axi_awaddr > OFS_POS |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_UNMAPPED_R: assert property (s_axi_arready && s_axi_araddr > OFS_POS
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
  AST_STEP_SPACING: assert property (laser_on && lit_q && moved |-> gap_q >= MIN_GAP)
    else $error("drawn steps too close");

  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  COV_DRAW_STEP: cover property (laser_on && moved);
  COV_JUMP_STEP: cover property (!laser_on && moved);
endmodule : ramp_monitor

bind vector_ramp ramp_monitor #(.TWO_AXIS(TWO_AXIS)) ramp_monitor_i (.*);
`default_nettype wire

/* dv/test_vector_ramp.sv */
// Self-checking bench for the vector ramp generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_vector_ramp
  import ramp_pkg::*;
;
  logic        ref_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, laser_on;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] dac_x, dac_y;
  logic [15:0] px = 16'h8000;
  logic [15:0] py = 16'h8000;
  int          failures = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          mt[$];
  logic [32:0] mv[$];
  logic [7:0]  rofs[5] = '{OFS_STEP, OFS_DRAW_INC, OFS_JUMP_INC, OFS_PRE, OFS_POST};
  logic [15:0] rval[5] = '{STEP_RST_3AX, DRAW_INC_RST, JUMP_INC_RST, PRE_RST, POST_RST};

  vector_ramp #(.TWO_AXIS(1'b0)) vector_ramp_i (.*);
  host_link host_link_i (.*);

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Log every DAC move with its cycle and laser state
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (rst_b && (dac_x !== px || dac_y !== py))
    begin
      mv.push_back({laser_on, dac_y, dac_x});
      mt.push_back(cyc);
    end
    px <= dac_x;
    py <= dac_y;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic check_reset_values();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++)
    begin
      host_link_i.rd(rofs[i], d, r);
      `CHK("reset value", {16'h0000, rval[i]}, d)
    end
    host_link_i.rd(OFS_POS, d, r);
    `CHK("home position", {COORD_RST, COORD_RST}, d)
    host_link_i.rd(8'h40, d, r);
    `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {r, d})
    host_link_i.wr(8'h40, 32'h0000_0001, r);
    `CHK("unmapped write", RESP_SLVERR, r)
  endtask : check_reset_values

  task automatic check_rejects();
    logic [31:0] d;
    logic [1:0]  r;
    int          bi[7] = '{0, 0, 0, 1, 2, 3, 4};
    logic [31:0] bad[7] = '{32'h10d, 32'ha2, 32'hffff, 32'h0, 32'h8000, 32'h1, 32'h1_0002};
    int          gi[6] = '{0, 0, 1, 2, 3, 4};
    logic [15:0] good[6] = '{STEP_MAX, STEP_MIN_3AX, INC_MAX, INC_MIN, SETTLE_MAX, SETTLE_MIN};
    for (int i = 0; i < 7; i++)
    begin
      host_link_i.wr(rofs[bi[i]], bad[i], r);
      host_link_i.rd(rofs[bi[i]], d, r);
      `CHK("kept value", {16'h0000, rval[bi[i]]}, d)
      host_link_i.rd(OFS_STATUS, d, r);
      `CHK("reject flag", 1'b1, d[ST_REJECT_BIT])
      host_link_i.wr(OFS_STATUS, 32'h0000_0002, r);
    end
    for (int i = 0; i < 6; i++)
    begin
      host_link_i.wr(rofs[gi[i]], {16'h0000, good[i]}, r);
      host_link_i.rd(rofs[gi[i]], d, r);
      `CHK("edge value", {16'h0000, good[i]}, d)
    end
    host_link_i.rd(OFS_STATUS, d, r);
    `CHK("no reject", 1'b0, d[ST_REJECT_BIT])
  endtask : check_rejects

  task automatic run_vectors();
    logic [31:0] d;
    logic [1:0]  r;
    logic [32:0] ev[4] = '{{1'b0, 32'h8000_80c0}, {1'b0, 32'h8000_8180}, {1'b1, 32'h8040_8200},
                           {1'b1, 32'h8080_8280}};
    host_link_i.wr(OFS_JUMP_INC, 32'h0000_0100, r);
    host_link_i.wr(OFS_DRAW_INC, 32'h0000_0080, r);
    host_link_i.wr(OFS_PRE, 32'h0000_0002, r);
    host_link_i.wr(OFS_POST, {16'h0000, POST_RST}, r);
    host_link_i.pair(1'b1, 16'h8180, 16'h8000);
    host_link_i.pair(1'b0, 16'h8280, 16'h8080);
    host_link_i.wr(OFS_DRAW_INC, 32'h0000_0001, r);
    host_link_i.wr(OFS_STEP, 32'h0000_012c, r);
    host_link_i.wr(OFS_POST, 32'h0000_0002, r);
    host_link_i.rd(OFS_STATUS, d, r);
    `CHK("table count", 16'h0002, d[31:16])
    host_link_i.wr(OFS_CTRL, 32'h0000_0001, r);
    // Busy may take a cycle to show, so poll until it drops
    do host_link_i.rd(OFS_STATUS, d, r); while (d[ST_BUSY_BIT] !== 1'b0 || mv.size() == 0);
    `CHK("move count", 4, mv.size())
    for (int i = 0; i < 4 && i < mv.size(); i++)
      `CHK("dac step", ev[i], mv[i])
    if (mv.size() == 4)
    begin
      `CHK("jump step gap", 3000, mt[1] - mt[0])
      `CHK("draw step gap", 3000, mt[3] - mt[2])
      `CHK("settle short", 1'b1, (mt[2] - mt[1]) < 3300)
    end
    host_link_i.rd(OFS_POS, d, r);
    `CHK("end position", 32'h8080_8280, d)
    host_link_i.wr(OFS_CTRL, 32'h0000_0002, r);
    host_link_i.rd(OFS_STATUS, d, r);
    `CHK("cleared table", 16'h0000, d[31:16])
  endtask : run_vectors

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    summarize();
  end

  initial
  begin
    rst_b = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    check_reset_values();
    check_rejects();
    run_vectors();
    summarize();
  end
endmodule : test_vector_ramp
`default_nettype wire
